// ### hw/adaptive_boost_vout_controller.sv
// Purpose: Adaptive boost output code, soft-start, discharge and overvoltage control
// Assumes: APB slave; comparator flags synchronous to clk
// Notes: Switch gates are levels for the power stage
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "vout_ctrl_defines.svh"
module adaptive_boost_vout_controller
  import vout_ctrl_pkg::*;
#(
  parameter int DEBOUNCE_CYC = `DEBOUNCE_DEFAULT_CYC
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic torch_req, // Torch trigger
  input wire logic flash_req, // Flash trigger
  input wire logic headroom_low, // Regulator headroom below target
  input wire logic pchg_done, // Output at input minus 300mV
  input wire logic dis_done, // Output at input plus 200mV
  input wire logic fast_ov, // Output above fast OV threshold
  input wire logic at_min_duty, // Converter at minimum duty
  input wire logic at_ilim, // Peak input current limit
  input wire logic vout_high, // Output high enough to skip
  input wire logic [4:0] duty_need, // Required duty in 1/32 units
  output logic [8:0] vout_code, // Output voltage DAC code
  output logic [1:0] headroom_sel, // Headroom target select
  output logic [1:0] ls_gate, // Low-side gates per phase
  output logic hs_gate, // High-side switch on
  output logic out_hiz, // Output in true shutdown
  output logic reg_enable, // Current regulator enable
  output logic ov_fault // Overvoltage shutdown latched
);
  localparam logic [8:0] ONE = 9'h001;
  localparam logic [4:0] PCHG_ON = 5'(`PCHG_ON_CYC);
  localparam logic [4:0] DUTY_MIN = 5'(`DUTY_MIN_CYC);
  localparam logic [4:0] DUTY_MAX = 5'(`DUTY_MAX_CYC);

  logic [7:0] ctrl_r;
  logic [8:0] ss_lvl_r, ovp_lvl_r, code_r, code_nxt, last_r, peak_r;
  seq_state_t st_r, st_nxt;
  logic [9:0] tick_r;
  logic [14:0] deb_r;
  logic fault_r, event_r, trig_q_r;
  logic [1:0] mode_q_r;

  // APB decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = paddr == `ADDR_CTRL;
  wire hit_ss = paddr == `ADDR_SSLVL;
  wire hit_ovp = paddr == `ADDR_OVPLVL;
  wire hit_last = paddr == `ADDR_LAST;
  wire hit_peak = paddr == `ADDR_PEAK;
  wire hit_stat = paddr == `ADDR_STATUS;
  wire hit_code = paddr == `ADDR_CODE;
  wire mapped = hit_ctrl | hit_ss | hit_ovp | hit_last | hit_peak | hit_stat | hit_code;
  wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_r} :
                       hit_ss ? {23'h0, ss_lvl_r} :
                       hit_ovp ? {23'h0, ovp_lvl_r} :
                       hit_last ? {23'h0, last_r} :
                       hit_peak ? {23'h0, peak_r} :
                       hit_stat ? {26'h0, event_r, fault_r, 1'b0, st_r} :
                       hit_code ? {23'h0, code_r} : 32'h0;

  boost_operating_mode_t mode;
  assign mode = boost_operating_mode_t'(ctrl_r[`CTRL_MODE_LO +: 2]);
  wire skip_en = ctrl_r[`CTRL_SKIP_BIT];
  wire auto_freq = ctrl_r[`CTRL_AUTOF_BIT];
  wire [1:0] freq_sel = ctrl_r[`CTRL_FREQ_LO +: 2];

  wire trig = (torch_req || flash_req) && !fault_r;
  wire mode_chg = mode != boost_operating_mode_t'(mode_q_r);
  wire step_soft = tick_r >= 10'(`SOFT_STEP_CYC - 1);
  wire step_norm = tick_r >= 10'(`NORM_STEP_CYC - 1);
  wire at_ss = code_r >= ss_lvl_r;
  wire want_up = headroom_low && !at_ilim;
  wire over_req = want_up && (code_r >= ovp_lvl_r);
  wire deb_exp = over_req && (deb_r >= 15'(DEBOUNCE_CYC - 1));
  wire trip = fast_ov || deb_exp;
  wire active_req = (mode != MODE_LOW_POWER) || trig;

  // Sequencer
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_OFF: st_nxt = (active_req && !fault_r && (mode_chg || trig || mode != MODE_LOW_POWER)) ? ST_PCHG : ST_OFF;
      ST_PCHG: st_nxt = pchg_done ? ((mode == MODE_DROPOUT) ? ST_FULLON : ST_RAMP) : ST_PCHG;
      ST_RAMP: st_nxt = at_ss ? ST_REG : ST_RAMP;
      ST_REG: st_nxt = ST_REG;
      ST_FULLON: st_nxt = ST_FULLON;
      ST_DIS_SW: st_nxt = dis_done ? ST_DIS_ON : ST_DIS_SW;
      ST_DIS_ON: st_nxt = ST_OFF;
      default: st_nxt = ST_OFF;
    endcase
    if (trip && st_r != ST_OFF) begin
      st_nxt = ST_OFF;
    end else if (!active_req && st_r inside {ST_PCHG, ST_RAMP, ST_REG}) begin
      st_nxt = ST_DIS_SW;
    end else if (!active_req && st_r == ST_FULLON) begin
      st_nxt = ST_OFF;
    end else if (mode_chg && mode != MODE_LOW_POWER && st_r inside {ST_REG, ST_FULLON}) begin
      st_nxt = ST_PCHG;
    end
  end

  // Code update
  wire adapt = (st_r == ST_REG) && event_r && (mode != MODE_FIXED);
  wire may_down = !at_min_duty && !headroom_low && code_r != 9'h000;
  wire may_up = want_up && !over_req && code_r != 9'h1FF;
  always_comb begin
    code_nxt = code_r;
    if (st_r == ST_OFF || st_r == ST_PCHG) begin
      code_nxt = 9'h000;
    end else if (st_r == ST_RAMP && step_soft && !at_ss) begin
      code_nxt = code_r + ONE;
    end else if (adapt && step_norm) begin
      if (may_up) begin
        code_nxt = code_r + ONE;
      end else if (may_down) begin
        // Current limit still lets the loop step down
        code_nxt = code_r - ONE;
      end
    end else if (st_r == ST_REG && mode == MODE_FIXED) begin
      code_nxt = ss_lvl_r;
    end
  end

  wire [4:0] duty_c = (duty_need < DUTY_MIN) ? DUTY_MIN : (duty_need > DUTY_MAX) ? DUTY_MAX : duty_need;
  wire div_auto = duty_need < 5'h04;
  wire period_div = auto_freq ? !div_auto : freq_sel[0];
  wire sw_run = st_r inside {ST_RAMP, ST_REG};
  wire [1:0] ls_w;
  pwm_gen u_pwm (
    .clk(clk),
    .reset_n(reset_n),
    .run(sw_run),
    .on_cyc(duty_c),
    .period_div(period_div),
    .skip_now(skip_en && vout_high),
    .ls_on(ls_w),
    .period_start()
  );
  logic [4:0] pc_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= `CTRL_RST;
      ss_lvl_r <= `SSLVL_RST;
      ovp_lvl_r <= `OVP_RST;
    end else if (wr && hit_ctrl) begin
      ctrl_r <= pwdata[7:0];
    end else if (wr && hit_ss) begin
      ss_lvl_r <= pwdata[8:0];
    end else if (wr && hit_ovp) begin
      ovp_lvl_r <= pwdata[8:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr inside {`ADDR_CTRL, `ADDR_SSLVL, `ADDR_OVPLVL, `ADDR_LAST,
                                                     `ADDR_PEAK, `ADDR_STATUS, `ADDR_CODE});
      prdata <= (psel && !penable && !pwrite && mapped) ? rd_mux : prdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_OFF;
      code_r <= 9'h000;
      tick_r <= 10'h000;
      mode_q_r <= 2'b00;
      trig_q_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      // Mode 01 resumes from last code
      // Hold the code being logged; last_r only updates at this same edge
      code_r <= (st_r == ST_REG && mode == MODE_PREBIAS && event_r && !trig) ? code_r : code_nxt;
      tick_r <= (step_norm || (st_r == ST_RAMP && step_soft) || st_r != st_nxt) ? 10'h000 : tick_r + 10'h001;
      mode_q_r <= mode;
      trig_q_r <= trig;
    end
  end

  // Event flag, debounce and fault
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      event_r <= 1'b0;
      deb_r <= 15'h0000;
      fault_r <= 1'b0;
      last_r <= 9'h000;
      peak_r <= 9'h000;
    end else begin
      event_r <= trig && !trip && st_r == ST_REG && mode inside {MODE_LOW_POWER, MODE_PREBIAS};
      deb_r <= over_req && adapt ? deb_r + 15'h0001 : 15'h0000;
      if (trip) begin
        fault_r <= 1'b1;
      end else if (wr && hit_stat && pwdata[5]) begin
        fault_r <= 1'b0;
      end
      if (event_r && !(trig && !trip)) begin
        last_r <= code_r;
      end
      if (trig && !trig_q_r) begin
        peak_r <= code_r;
      end else if (event_r && code_r > peak_r) begin
        peak_r <= code_r;
      end
    end
  end

  // Output drive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_r <= 5'h00;
      vout_code <= 9'h000;
      headroom_sel <= 2'b00;
      ls_gate <= 2'b00;
      hs_gate <= 1'b0;
      out_hiz <= 1'b1;
      reg_enable <= 1'b0;
      ov_fault <= 1'b0;
    end else begin
      pc_r <= pc_r + 5'h01;
      vout_code <= code_r;
      headroom_sel <= ctrl_r[`CTRL_HEAD_LO +: 2];
      // Gate with state so no stale pulse leaks into shutdown
      ls_gate <= sw_run ? ls_w : 2'b00;
      hs_gate <= (st_r inside {ST_PCHG, ST_DIS_SW}) ? (pc_r < PCHG_ON) :
                 (st_r inside {ST_FULLON, ST_DIS_ON}) ? 1'b1 :
                 sw_run ? (ls_w == 2'b00) : 1'b0;
      out_hiz <= st_r == ST_OFF;
      reg_enable <= event_r && !trip;
      ov_fault <= fault_r;
    end
  end
endmodule // adaptive_boost_vout_controller

// ### inc/vout_ctrl_defines.svh
// Purpose: Offsets, fields, reset values and timing counts for the boost output controller
// Assumes: 100 MHz clock, APB with 32-bit data
// Notes: Included by its bare name
`ifndef VOUT_CTRL_DEFINES_SVH
`define VOUT_CTRL_DEFINES_SVH

`define CLK_MHZ 100
`define SOFT_STEP_US 1
`define NORM_STEP_US 8
`define SOFT_STEP_CYC (`SOFT_STEP_US * `CLK_MHZ)
`define NORM_STEP_CYC (`NORM_STEP_US * `CLK_MHZ)
`define PWM_PERIOD_CYC 32
`define PCHG_ON_CYC 8
`define DUTY_MIN_CYC 1
`define DUTY_MAX_CYC 24
`define DEBOUNCE_DEFAULT_CYC 20000

`define CODE_W 9

`define ADDR_CTRL 12'h000
`define ADDR_SSLVL 12'h004
`define ADDR_OVPLVL 12'h008
`define ADDR_LAST 12'h00C
`define ADDR_PEAK 12'h010
`define ADDR_STATUS 12'h014
`define ADDR_CODE 12'h018

`define CTRL_MODE_LO 0
`define CTRL_SKIP_BIT 2
`define CTRL_AUTOF_BIT 3
`define CTRL_FREQ_LO 4
`define CTRL_HEAD_LO 6
`define CTRL_RST 8'h00
`define SSLVL_RST 9'h040
`define OVP_RST 9'h180

`endif

// ### inc/vout_ctrl_pkg.sv
// Purpose: Types for the boost output controller
// Assumes: Nothing beyond the defines header
// Notes: Modes and sequencer states
package vout_ctrl_pkg;
  typedef enum logic [1:0] {
    MODE_LOW_POWER = 2'b00,
    MODE_PREBIAS = 2'b01,
    MODE_FIXED = 2'b10,
    MODE_DROPOUT = 2'b11
  } boost_operating_mode_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_PCHG = 3'b001,
    ST_RAMP = 3'b010,
    ST_REG = 3'b011,
    ST_FULLON = 3'b100,
    ST_DIS_SW = 3'b101,
    ST_DIS_ON = 3'b110
  } seq_state_t;
endpackage

// ### hw/pwm_gen.sv
// Purpose: Per-phase switching waveform from a period counter
// Assumes: Period of PWM_PERIOD_CYC clocks, twice that when period_div is set, two phases half a period apart
// Notes: Skip drops one whole cycle; outputs registered
`timescale 1ns/1ps
`include "vout_ctrl_defines.svh"
module pwm_gen (
  input wire logic clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic run, // Switching allowed
  input wire logic [4:0] on_cyc, // Low-side on clocks per period, doubled when rate halved
  input wire logic period_div, // Halve switching rate
  input wire logic skip_now, // Omit next cycle
  output logic [1:0] ls_on, // Low-side gates per phase
  output logic period_start // Start of phase A cycle
);
  logic [5:0] cnt_r;
  logic skip_r;
  logic [5:0] len;
  logic wrap;
  assign len = period_div ? 6'h3F : 6'h1F;
  assign wrap = (cnt_r == len);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 6'h00;
      skip_r <= 1'b0;
      period_start <= 1'b0;
    end else begin
      cnt_r <= (wrap || !run) ? 6'h00 : cnt_r + 6'h01;
      period_start <= wrap && run;
      if (wrap) begin
        skip_r <= skip_now;
      end
    end
  end
  genvar ph;
  generate
    for (ph = 0; ph < 2; ph++) begin : g_phase
      logic [5:0] pos;
      assign pos = (ph == 0) ? cnt_r : ((cnt_r + (len >> 1) + 6'h01) & len);
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          ls_on[ph] <= 1'b0;
        end else begin
          ls_on[ph] <= run && !skip_r && (pos < {(period_div ? {on_cyc, 1'b0} : {1'b0, on_cyc})});
        end
      end
    end
  endgenerate
endmodule // pwm_gen

// ### sim/vout_ctrl_chk_assertions.sv
// Purpose: Port checks for the boost output controller
// Assumes: Zero-wait APB, registered outputs
// Notes: Mirrors ctrl and OV level from APB writes
`timescale 1ns/1ps
`include "vout_ctrl_defines.svh"
module vout_ctrl_chk #(parameter int DEBOUNCE_CYC = 50) (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic psel, // APB
  input wire logic penable, // APB
  input wire logic pwrite, // APB
  input wire logic [11:0] paddr, // APB
  input wire logic [31:0] pwdata, // APB
  input wire logic pready, // APB
  input wire logic at_min_duty, // Flag
  input wire logic at_ilim, // Flag
  input wire logic fast_ov, // Flag
  input wire logic [8:0] vout_code, // Code
  input wire logic [1:0] headroom_sel, // Select
  input wire logic [1:0] ls_gate, // Gates
  input wire logic hs_gate, // Gate
  input wire logic out_hiz, // Shutdown
  input wire logic reg_enable, // Regulator
  input wire logic ov_fault // Fault
);
  logic [7:0] ctrl_r;
  logic [8:0] ovp_r;
  wire wr_hit = psel && penable && pready && pwrite;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= `CTRL_RST;
      ovp_r <= `OVP_RST;
    end else if (wr_hit && paddr == `ADDR_CTRL) begin
      ctrl_r <= pwdata[7:0];
    end else if (wr_hit && paddr == `ADDR_OVPLVL) begin
      ovp_r <= pwdata[8:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_step_one_lsb: assert property (reg_enable && $past(reg_enable) |->
    (vout_code - $past(vout_code)) inside {9'h000, 9'h001, 9'h1FF}) else $error("code jumped");
  a_step_spacing: assert property (reg_enable && $changed(vout_code) |=>
    ($stable(vout_code) || !reg_enable) [*8]) else $error("steps too close");
  a_min_duty_up: assert property ((at_min_duty && reg_enable) [*3] |->
    vout_code >= $past(vout_code)) else $error("down step at min duty");
  a_ilim_down: assert property ((at_ilim && reg_enable) [*3] |->
    vout_code <= $past(vout_code)) else $error("up step at current limit");
  a_ov_clamp: assert property (vout_code <= ovp_r) else $error("code above OV level");
  a_slow_ov_off: assert property ($rose(ov_fault) |-> ##[0:2]
    (!reg_enable && ls_gate == 2'b00)) else $error("fault left power on");
  a_fast_ov_off: assert property (fast_ov |-> ##[1:3]
    (ov_fault && !reg_enable && ls_gate == 2'b00)) else $error("fast OV ignored");
  a_hiz_quiet: assert property (out_hiz |->
    (!hs_gate && ls_gate == 2'b00 && !reg_enable)) else $error("switching in shutdown");
  a_headroom_map: assert property (headroom_sel == $past(ctrl_r[7:6])) else $error("headroom select");
endmodule // vout_ctrl_chk

bind adaptive_boost_vout_controller vout_ctrl_chk #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) chk_u (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .at_min_duty(at_min_duty), .at_ilim(at_ilim), .fast_ov(fast_ov),
  .vout_code(vout_code), .headroom_sel(headroom_sel), .ls_gate(ls_gate), .hs_gate(hs_gate),
  .out_hiz(out_hiz), .reg_enable(reg_enable), .ov_fault(ov_fault));

// ### sim/boost_stage_model.sv
// Purpose: Power stage and LED stand-in
// Assumes: Output charge counted in high-side on cycles
// Notes: Heavy load keeps the output from charging
`timescale 1ns/1ps
module boost_stage_model (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic hs_gate, // High side
  input wire logic [1:0] ls_gate, // Low sides
  input wire logic out_hiz, // Shutdown
  input wire logic [8:0] vout_code, // Code
  input wire logic [8:0] vf_code, // LED need
  input wire logic heavy_load, // Over 10mA
  output logic pchg_done, // Charged
  output logic dis_done, // Discharged
  output logic headroom_low // Short
);
  logic [5:0] chg_r;
  logic [5:0] dis_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) chg_r <= 6'h00;
    else if (out_hiz || heavy_load) chg_r <= 6'h00;
    else if (hs_gate && chg_r != 6'h3F) chg_r <= chg_r + 6'h01;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) dis_r <= 6'h00;
    else if (ls_gate != 2'b00) dis_r <= 6'h00;
    else if (hs_gate && dis_r != 6'h3F) dis_r <= dis_r + 6'h01;
  end
  assign pchg_done = chg_r >= 6'h10;
  assign dis_done = dis_r >= 6'h0C;
  assign headroom_low = vout_code < vf_code;
endmodule // boost_stage_model

// ### sim/test_adaptive_boost_vout_controller.sv
// Purpose: Register-driven test of the boost output controller
// Assumes: Zero-wait APB slave, stage model beside it
// Notes: Short debounce keeps the OV run brief
`timescale 1ns/1ps
`include "vout_ctrl_defines.svh"
module test_adaptive_boost_vout_controller;
  import vout_ctrl_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic torch_req = 1'b0, flash_req = 1'b0, at_min_duty = 1'b0, at_ilim = 1'b0;
  logic fast_ov = 1'b0, vout_high = 1'b0, heavy_load = 1'b0, pready, pslverr, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [8:0] vf_code = 9'h018, vout_code;
  logic [1:0] headroom_sel, ls_gate;
  logic hs_gate, out_hiz, reg_enable, ov_fault, pchg_done, dis_done, headroom_low;
  int err_total = 0, n_compared = 0, k;
  always #5 clk = ~clk;
  adaptive_boost_vout_controller #(.DEBOUNCE_CYC(50)) dut_u (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .torch_req(torch_req), .flash_req(flash_req),
    .headroom_low(headroom_low), .pchg_done(pchg_done), .dis_done(dis_done), .fast_ov(fast_ov),
    .at_min_duty(at_min_duty), .at_ilim(at_ilim), .vout_high(vout_high), .duty_need(5'h08),
    .vout_code(vout_code), .headroom_sel(headroom_sel), .ls_gate(ls_gate), .hs_gate(hs_gate),
    .out_hiz(out_hiz), .reg_enable(reg_enable), .ov_fault(ov_fault));
  boost_stage_model pwr_u (.clk(clk), .reset_n(reset_n), .hs_gate(hs_gate), .ls_gate(ls_gate),
    .out_hiz(out_hiz), .vout_code(vout_code), .vf_code(vf_code), .heavy_load(heavy_load),
    .pchg_done(pchg_done), .dis_done(dis_done), .headroom_low(headroom_low));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_reg(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
    apb(1'b0, a, 32'h0);
    for (int i = 0; i < 3000 && (q & m) !== v; i++) apb(1'b0, a, 32'h0);
    chk(q & m, v);
  endtask
  task automatic wait_hi(input logic which);
    for (int i = 0; i < 5000; i++) begin
      if ((which ? reg_enable : out_hiz) === 1'b1) break;
      @(posedge clk);
    end
    chk(which ? reg_enable : out_hiz, 32'h1);
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #900000;
    err_total++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    chk(out_hiz, 32'h1);
    apb(1'b0, `ADDR_SSLVL, 32'h0);
    chk(q, 32'h040);
    apb(1'b0, 12'h01C, 32'h0);
    chk(e, 32'h1);
    apb(1'b1, `ADDR_SSLVL, 32'h010);
    heavy_load <= 1'b1;
    apb(1'b1, `ADDR_CTRL, 32'h01);
    repeat (2000) @(posedge clk);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(q[2:0], ST_PCHG);
    heavy_load <= 1'b0;
    wait_reg(`ADDR_STATUS, 32'h7, ST_REG);
    apb(1'b0, `ADDR_CODE, 32'h0);
    chk(q, 32'h010);
    torch_req <= 1'b1;
    repeat (5) @(posedge clk);
    chk(reg_enable, 32'h1);
    wait_reg(`ADDR_CODE, 32'h1FF, 32'h018);
    at_min_duty <= 1'b1;
    vf_code <= 9'h010;
    repeat (2000) @(posedge clk);
    apb(1'b0, `ADDR_CODE, 32'h0);
    chk(q, 32'h018);
    at_min_duty <= 1'b0;
    vf_code <= 9'h014;
    wait_reg(`ADDR_CODE, 32'h1FF, 32'h014);
    at_ilim <= 1'b1;
    vf_code <= 9'h030;
    repeat (2000) @(posedge clk);
    apb(1'b0, `ADDR_CODE, 32'h0);
    chk(q, 32'h014);
    at_ilim <= 1'b0;
    vf_code <= 9'h016;
    wait_reg(`ADDR_CODE, 32'h1FF, 32'h016);
    torch_req <= 1'b0;
    apb(1'b0, `ADDR_LAST, 32'h0);
    chk(q, 32'h016);
    apb(1'b0, `ADDR_PEAK, 32'h0);
    chk(q, 32'h018);
    repeat (1000) @(posedge clk);
    apb(1'b0, `ADDR_CODE, 32'h0);
    chk(q, 32'h016);
    apb(1'b1, `ADDR_OVPLVL, 32'h019);
    vf_code <= 9'h040;
    torch_req <= 1'b1;
    wait_reg(`ADDR_STATUS, 32'h10, 32'h10);
    chk(reg_enable, 32'h0);
    torch_req <= 1'b0;
    vf_code <= 9'h010;
    apb(1'b1, `ADDR_STATUS, 32'h20);
    wait_reg(`ADDR_STATUS, 32'h17, ST_REG);
    torch_req <= 1'b1;
    repeat (5) @(posedge clk);
    fast_ov <= 1'b1;
    @(posedge clk);
    fast_ov <= 1'b0;
    repeat (3) @(posedge clk);
    chk(ov_fault, 32'h1);
    torch_req <= 1'b0;
    apb(1'b1, `ADDR_STATUS, 32'h20);
    apb(1'b1, `ADDR_CTRL, 32'hC2);
    wait_reg(`ADDR_STATUS, 32'h17, ST_REG);
    chk(headroom_sel, 32'h3);
    torch_req <= 1'b1;
    repeat (20) @(posedge clk);
    chk(reg_enable, 32'h0);
    vout_high <= 1'b1;
    apb(1'b1, `ADDR_CTRL, 32'hC6);
    repeat (70) @(posedge clk);
    k = 0;
    repeat (70) begin
      @(posedge clk);
      if (ls_gate !== 2'b00) k++;
    end
    chk(k, 32'h0);
    vout_high <= 1'b0;
    repeat (70) begin
      @(posedge clk);
      if (ls_gate !== 2'b00) k++;
    end
    chk(k != 0, 32'h1);
    torch_req <= 1'b0;
    apb(1'b1, `ADDR_CTRL, 32'h00);
    wait_hi(1'b0);
    flash_req <= 1'b1;
    wait_hi(1'b1);
    flash_req <= 1'b0;
    wait_hi(1'b0);
    apb(1'b1, `ADDR_CTRL, 32'h03);
    wait_reg(`ADDR_STATUS, 32'h7, ST_FULLON);
    repeat (10) @(posedge clk);
    chk(hs_gate, 32'h1);
    apb(1'b1, `ADDR_CTRL, 32'h00);
    wait_hi(1'b0);
    test_done;
  end
endmodule // test_adaptive_boost_vout_controller
